// ### verilog/pin_mux_pkg.sv
package pin_mux_pkg;
   // =====================================================
   // operating modes, from the mode pins
   // =====================================================
   localparam logic [2:0] MODE_EXP_NOROM_A = 3'h4;
   localparam logic [2:0] MODE_EXP_NOROM_B = 3'h5;
   localparam logic [2:0] MODE_EXP_ROM     = 3'h6;
   localparam logic [2:0] MODE_SINGLE      = 3'h7;
   // =====================================================
   // port F pin positions
   // =====================================================
   localparam int PF_BUS_REQ  = 0;
   localparam int PF_LWR      = 3;
   localparam int PF_HWR      = 4;
   localparam int PF_RD       = 5;
   localparam int PF_AS       = 6;
   localparam int PF_CLK      = 7;
   // =====================================================
   // port G pin positions
   // =====================================================
   localparam int PG_CS3      = 1;
   localparam int PG_CS2      = 2;
   localparam int PG_CS1      = 3;
   localparam int PG_CS0      = 4;
   // =====================================================
   // reset values
   // =====================================================
   localparam logic       RST_BUS_RELEASE = 1'b0;
   localparam logic [7:0] RST_DDR8        = 8'h00;
   localparam logic [7:0] RST_PF_DDR      = 8'h80;
   localparam logic [4:0] RST_PG_DDR      = 5'h00;
endpackage

// ### verilog/pin_cell.sv
`timescale 1ns/100ps
// =====================================================
// one pin: selects bus or gpio drive, registered
// =====================================================
module pin_cell (
   input  wire logic clock_i,
   input  wire logic nrst_i,
   input  wire logic bus_sel_i,
   input  wire logic bus_out_i,
   input  wire logic bus_oe_i,
   input  wire logic gpio_out_i,
   input  wire logic gpio_dir_i,
   input  wire logic pu_en_i,
   output logic      pin_out_o,
   output logic      pin_oe_n_o,
   output logic      pin_pu_o
);
   typedef struct packed {
      logic out;
      logic oe_n;
      logic pu;
   } cell_t;
   cell_t st_r;
   cell_t st_nxt;

   always_comb begin
      st_nxt.out  = bus_sel_i ? bus_out_i : gpio_out_i;
      st_nxt.oe_n = bus_sel_i ? ~bus_oe_i : ~gpio_dir_i;
      // pull-up only while the pin is an input
      st_nxt.pu   = pu_en_i & st_nxt.oe_n;
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '{out: 1'b0, oe_n: 1'b1, pu: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_out_o  = st_r.out;
   assign pin_oe_n_o = st_r.oe_n;
   assign pin_pu_o   = st_r.pu;
endmodule

// ### verilog/port_pin_function_select.sv
// Behaviour
// R1: in expanded modes the clock pin is an input at direction 0 and drives the clock at 1, reset 1.
// R2: in expanded modes port F drives address, read and high write strobes, and low write on 16 bits.
// R3: with an 8-bit bus the low-write pin is general I/O feeding irq 3 and the converter trigger.
// R4: with bus release off (reset) the bus-request pin is general I/O feeding irq 2.
// R5: with bus release on in expanded modes the pin is sampled as bus request, still feeding irq 2.
// R6: in expanded modes chip-select-0 pin is an input at direction 0, the reset state of mode 6.
// R7: in expanded modes chip-select-0 pin drives select 0 low-active at direction 1.
// R8: chip selects 1 to 3 drive at direction 1; the select-3 pin feeds irq 7 in both directions.
// R9: address-low and both data ports offer an input pull-up per pin.
// R10: after a reset into modes 4 or 5 the select-0 direction is 1 from the first edge, driving select 0 from the second.
// R11: in single-chip mode address-low and data ports are general I/O only.
// R12: in expanded modes upper data port carries bits 15..8, lower port bits 7..0 on 16 bits only.
`timescale 1ns/100ps
module port_pin_function_select
   import pin_mux_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic [2:0]  mode_i,
   input  wire logic        bus_16bit_i,
   input  wire logic        bus_release_enable_i,
   input  wire logic        ddr_write_i,
   input  wire logic [7:0]  pc_ddr_i,
   input  wire logic [7:0]  pd_ddr_i,
   input  wire logic [7:0]  pe_ddr_i,
   input  wire logic [7:0]  pf_ddr_i,
   input  wire logic [4:0]  pg_ddr_i,
   input  wire logic [7:0]  pc_gpio_i,
   input  wire logic [7:0]  pd_gpio_i,
   input  wire logic [7:0]  pe_gpio_i,
   input  wire logic [7:0]  pf_gpio_i,
   input  wire logic [4:0]  pg_gpio_i,
   input  wire logic [7:0]  pu_en_c_i,
   input  wire logic [7:0]  pu_en_d_i,
   input  wire logic [7:0]  pu_en_e_i,
   input  wire logic [7:0]  addr_low_i,
   input  wire logic [15:0] data_out_i,
   input  wire logic        data_oe_i,
   input  wire logic        sys_clock_i,
   input  wire logic        addr_strobe_n_i,
   input  wire logic        read_strobe_n_i,
   input  wire logic        high_write_strobe_n_i,
   input  wire logic        low_write_strobe_n_i,
   input  wire logic [3:0]  chip_sel_n_i,
   input  wire logic [7:0]  pf_pin_i,
   input  wire logic [4:0]  pg_pin_i,
   output logic [7:0]       pc_out_o,
   output logic [7:0]       pc_oe_n_o,
   output logic [7:0]       pc_pu_o,
   output logic [7:0]       pd_out_o,
   output logic [7:0]       pd_oe_n_o,
   output logic [7:0]       pd_pu_o,
   output logic [7:0]       pe_out_o,
   output logic [7:0]       pe_oe_n_o,
   output logic [7:0]       pe_pu_o,
   output logic [7:0]       pf_out_o,
   output logic [7:0]       pf_oe_n_o,
   output logic [4:0]       pg_out_o,
   output logic [4:0]       pg_oe_n_o,
   output logic             bus_request_in_o,
   output logic             ext_irq_in_2_o,
   output logic             ext_irq_in_3_o,
   output logic             ext_irq_in_7_o,
   output logic             converter_trigger_in_o,
   output logic             pf_ddr_o,
   output logic             pg_ddr0_o
);
   // =====================================================
   // state
   // =====================================================
   typedef struct packed {
      logic [7:0] pc_ddr;
      logic [7:0] pd_ddr;
      logic [7:0] pe_ddr;
      logic [7:0] pf_ddr;
      logic [4:0] pg_ddr;
      logic       strap_done;
      logic       bus_req;
      logic       ext_irq_in_2;
      logic       ext_irq_in_3;
      logic       ext_irq_in_7;
      logic       trig;
   } state_t;
   state_t st_r;
   state_t st_nxt;

   logic expanded;
   logic [7:0]  pf_sel;
   logic [7:0]  pf_bus;
   logic [7:0]  pf_bus_oe;
   logic [4:0]  pg_sel;
   logic [4:0]  pg_bus;
   logic [15:0] d_sel;

   assign expanded = (mode_i != MODE_SINGLE);

   // =====================================================
   // direction registers and sampled inputs
   // =====================================================
   always_comb begin
      st_nxt = st_r;
      if (ddr_write_i) begin
         st_nxt.pc_ddr = pc_ddr_i;
         st_nxt.pd_ddr = pd_ddr_i;
         st_nxt.pe_ddr = pe_ddr_i;
         st_nxt.pf_ddr = pf_ddr_i;
         st_nxt.pg_ddr = pg_ddr_i;
      end
      // mode pins are a strap: caught on the first edge after release
      if (!st_r.strap_done) begin
         st_nxt.strap_done = 1'b1;
         st_nxt.pf_ddr[PF_CLK] = expanded;  // see R1
         if (mode_i == MODE_EXP_NOROM_A || mode_i == MODE_EXP_NOROM_B) begin
            st_nxt.pg_ddr[PG_CS0] = 1'b1;  // see R10
         end else begin
            st_nxt.pg_ddr[PG_CS0] = 1'b0;  // see R6
         end
      end
      // pins are sampled in every function but the 16-bit low-write strobe, so interrupts keep seeing them
      st_nxt.bus_req = (expanded && bus_release_enable_i) ? pf_pin_i[PF_BUS_REQ] : 1'b1;  // see R5
      st_nxt.ext_irq_in_2    = pf_pin_i[PF_BUS_REQ];  // see R4
      st_nxt.ext_irq_in_3    = (expanded && bus_16bit_i) ? 1'b1 : pf_pin_i[PF_LWR];  // see R3
      st_nxt.trig    = (expanded && bus_16bit_i) ? 1'b1 : pf_pin_i[PF_LWR];  // see R3
      st_nxt.ext_irq_in_7    = pg_pin_i[PG_CS3];  // see R8
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '{pc_ddr: RST_DDR8, pd_ddr: RST_DDR8, pe_ddr: RST_DDR8,
                   pf_ddr: RST_PF_DDR, pg_ddr: RST_PG_DDR, strap_done: 1'b0,
                   bus_req: 1'b1, ext_irq_in_2: 1'b1, ext_irq_in_3: 1'b1, ext_irq_in_7: 1'b1, trig: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================
   // function selection
   // =====================================================
   always_comb begin
      pf_sel    = 8'h00;
      pf_bus    = 8'hff;
      pf_bus_oe = 8'h00;
      pg_sel    = 5'h00;
      pg_bus    = 5'h1f;
      d_sel     = 16'h0000;
      // clock pin carries the clock in every mode; only its direction bit gates it
      pf_sel[PF_CLK]    = 1'b1;  // see R1
      pf_bus[PF_CLK]    = sys_clock_i;
      pf_bus_oe[PF_CLK] = st_r.pf_ddr[PF_CLK];
      if (expanded) begin
         pf_sel[PF_AS] = 1'b1;  // see R2
         pf_sel[PF_RD] = 1'b1;
         pf_sel[PF_HWR] = 1'b1;
         pf_bus[PF_AS] = addr_strobe_n_i;
         pf_bus[PF_RD] = read_strobe_n_i;
         pf_bus[PF_HWR] = high_write_strobe_n_i;
         pf_bus_oe[PF_AS] = 1'b1;
         pf_bus_oe[PF_RD] = 1'b1;
         pf_bus_oe[PF_HWR] = 1'b1;
         pf_sel[PF_LWR] = bus_16bit_i;  // see R2
         pf_bus[PF_LWR] = low_write_strobe_n_i;
         pf_bus_oe[PF_LWR] = 1'b1;
         // bus-request pin becomes input-only while release is on
         pf_sel[PF_BUS_REQ] = bus_release_enable_i;  // see R5
         // select 0 stays bus-owned; its direction bit alone gates the drive
         pg_sel[PG_CS0] = 1'b1;  // see R6
         pg_sel[PG_CS1] = st_r.pg_ddr[PG_CS1];  // see R8
         pg_sel[PG_CS2] = st_r.pg_ddr[PG_CS2];
         pg_sel[PG_CS3] = st_r.pg_ddr[PG_CS3];
         pg_bus[PG_CS0] = chip_sel_n_i[0];  // see R7
         pg_bus[PG_CS1] = chip_sel_n_i[1];
         pg_bus[PG_CS2] = chip_sel_n_i[2];
         pg_bus[PG_CS3] = chip_sel_n_i[3];
         d_sel[15:8] = 8'hff;  // see R12
         // an 8-bit bus leaves the lower data port to gpio
         d_sel[7:0] = bus_16bit_i ? 8'hff : 8'h00;
      end
   end

   // =====================================================
   // pin cells; single-chip leaves all of C, D, E as gpio
   // =====================================================
   // bus drive is registered too, so every pin lags a bus input by one cycle and a direction write by two
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g8
         pin_cell u_c (.clock_i(clock_i), .nrst_i(nrst_i), .bus_sel_i(expanded),  // see R11
            .bus_out_i(addr_low_i[i]), .bus_oe_i(1'b1), .gpio_out_i(pc_gpio_i[i]),
            .gpio_dir_i(st_r.pc_ddr[i]), .pu_en_i(pu_en_c_i[i]),  // see R9
            .pin_out_o(pc_out_o[i]), .pin_oe_n_o(pc_oe_n_o[i]), .pin_pu_o(pc_pu_o[i]));
         pin_cell u_d (.clock_i(clock_i), .nrst_i(nrst_i), .bus_sel_i(d_sel[8+i]),
            .bus_out_i(data_out_i[8+i]), .bus_oe_i(data_oe_i), .gpio_out_i(pd_gpio_i[i]),
            .gpio_dir_i(st_r.pd_ddr[i]), .pu_en_i(pu_en_d_i[i]),
            .pin_out_o(pd_out_o[i]), .pin_oe_n_o(pd_oe_n_o[i]), .pin_pu_o(pd_pu_o[i]));
         pin_cell u_e (.clock_i(clock_i), .nrst_i(nrst_i), .bus_sel_i(d_sel[i]),
            .bus_out_i(data_out_i[i]), .bus_oe_i(data_oe_i), .gpio_out_i(pe_gpio_i[i]),
            .gpio_dir_i(st_r.pe_ddr[i]), .pu_en_i(pu_en_e_i[i]),
            .pin_out_o(pe_out_o[i]), .pin_oe_n_o(pe_oe_n_o[i]), .pin_pu_o(pe_pu_o[i]));
         pin_cell u_f (.clock_i(clock_i), .nrst_i(nrst_i), .bus_sel_i(pf_sel[i]),
            .bus_out_i(pf_bus[i]), .bus_oe_i(pf_bus_oe[i]), .gpio_out_i(pf_gpio_i[i]),
            .gpio_dir_i(st_r.pf_ddr[i]), .pu_en_i(1'b0),
            .pin_out_o(pf_out_o[i]), .pin_oe_n_o(pf_oe_n_o[i]), .pin_pu_o());
      end
      for (i = 0; i < 5; i++) begin : g5
         pin_cell u_g (.clock_i(clock_i), .nrst_i(nrst_i), .bus_sel_i(pg_sel[i]),
            .bus_out_i(pg_bus[i]), .bus_oe_i(st_r.pg_ddr[i]), .gpio_out_i(pg_gpio_i[i]),
            .gpio_dir_i(st_r.pg_ddr[i]), .pu_en_i(1'b0),
            .pin_out_o(pg_out_o[i]), .pin_oe_n_o(pg_oe_n_o[i]), .pin_pu_o());
      end
   endgenerate

   // sampled inputs and direction bits come straight from the state register
   assign bus_request_in_o       = st_r.bus_req;
   assign ext_irq_in_2_o         = st_r.ext_irq_in_2;
   assign ext_irq_in_3_o         = st_r.ext_irq_in_3;
   assign ext_irq_in_7_o         = st_r.ext_irq_in_7;
   assign converter_trigger_in_o = st_r.trig;
   assign pf_ddr_o               = st_r.pf_ddr[PF_CLK];
   assign pg_ddr0_o              = st_r.pg_ddr[PG_CS0];
endmodule

// ### tb/port_pin_function_select_chk.sv
`timescale 1ns/100ps
module port_pin_function_select_chk (
   input wire logic       clock_i, nrst_i, bus_16bit_i, bus_release_enable_i, sys_clock_i,
   input wire logic       addr_strobe_n_i, low_write_strobe_n_i, bus_request_in_o,
   input wire logic       ext_irq_in_2_o, ext_irq_in_3_o, ext_irq_in_7_o, converter_trigger_in_o,
   input wire logic       pf_ddr_o, pg_ddr0_o,
   input wire logic [2:0] mode_i,
   input wire logic [4:0] pg_pin_i, pg_oe_n_o,
   input wire logic [7:0] pf_pin_i, pf_out_o, pf_oe_n_o
);
   // ======================================
   // mode copy, caught once like the strap
   // ======================================
   logic [2:0] md_r;
   logic       seen_r;
   wire        ext = seen_r && (md_r != 3'h7);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) {seen_r, md_r} <= 4'h7;
      else if (!seen_r) {seen_r, md_r} <= {1'b1, mode_i};
   end
   default clocking dc @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   sequence s_boot_ext; $rose(seen_r) && (md_r == 3'h4 || md_r == 3'h5); endsequence
   // a lagging copy of the direction bit is covered by asking for two cycles
   sequence s_clk_dir; pf_ddr_o ##1 pf_ddr_o; endsequence
   // ======================================
   // routing, one cycle behind its cause
   // ======================================
   AST_ADDR_STROBE: assert property (
      ext |=> !pf_oe_n_o[6] && pf_out_o[6] == $past(addr_strobe_n_i)
   ) else $error("address strobe pin wrong");
   AST_LOW_WRITE_16: assert property (
      ext && bus_16bit_i |=> !pf_oe_n_o[3] && pf_out_o[3] == $past(low_write_strobe_n_i)
      && ext_irq_in_3_o && converter_trigger_in_o
   ) else $error("low write pin wrong");
   AST_EXT_IRQ_IN_3_8BIT: assert property (
      !bus_16bit_i |=> {ext_irq_in_3_o, converter_trigger_in_o} == {2{$past(pf_pin_i[3])}}
   ) else $error("ext_irq_in_3 or trigger wrong");
   AST_BUS_REQ_ON: assert property (
      ext && bus_release_enable_i |=> pf_oe_n_o[0] && bus_request_in_o == $past(pf_pin_i[0])
   ) else $error("bus request not sampled");
   AST_BUS_REQ_OFF: assert property (!bus_release_enable_i |=> bus_request_in_o)
      else $error("bus request active while off");
   AST_IRQ_PINS: assert property (
      1'b1 |=> ext_irq_in_2_o == $past(pf_pin_i[0]) && ext_irq_in_7_o == $past(pg_pin_i[1])
   ) else $error("ext_irq_in_2 or ext_irq_in_7 wrong");
   AST_CLOCK_OUT: assert property (
      s_clk_dir |-> !pf_oe_n_o[7] && pf_out_o[7] == $past(sys_clock_i)
   ) else $error("clock pin not driven");
   AST_BOOT_SELECT0: assert property (s_boot_ext |=> !pg_oe_n_o[4] && pg_ddr0_o)
      else $error("select 0 not driven after boot");
endmodule

// ### tb/bus_partner.sv
`timescale 1ns/100ps
// ======================================
// far-side pads: device drive wins
// ======================================
module bus_partner (
   input  wire logic [7:0] pf_out_i, pf_oe_n_i, far_f_i,
   input  wire logic [4:0] pg_out_i, pg_oe_n_i, far_g_i,
   output logic      [7:0] pf_pin_o,
   output logic      [4:0] pg_pin_o
);
   // released pins take a far level the bench changes every cycle, never the stale drive
   assign pf_pin_o = (pf_out_i & ~pf_oe_n_i) | (far_f_i & pf_oe_n_i);
   assign pg_pin_o = (pg_out_i & ~pg_oe_n_i) | (far_g_i & pg_oe_n_i);
endmodule

// ### tb/test_port_pin_function_select.sv
`timescale 1ns/100ps
module test_port_pin_function_select;
   logic        clock_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        bus_16bit_i, bus_release_enable_i, ddr_write_i, data_oe_i, sys_clock_i;
   logic        addr_strobe_n_i, read_strobe_n_i, high_write_strobe_n_i, low_write_strobe_n_i;
   logic        bus_request_in_o, ext_irq_in_2_o, ext_irq_in_3_o, ext_irq_in_7_o;
   logic        converter_trigger_in_o, pf_ddr_o, pg_ddr0_o, x;
   logic [2:0]  mode_i;
   logic [3:0]  chip_sel_n_i;
   logic [4:0]  pg_ddr_i, pg_gpio_i, pg_pin_i, pg_out_o, pg_oe_n_o, far_g, pgs, eg, ng;
   logic [7:0]  pc_ddr_i, pd_ddr_i, pe_ddr_i, pf_ddr_i, pc_gpio_i, pd_gpio_i, pe_gpio_i, pf_gpio_i;
   logic [7:0]  pu_en_c_i, pu_en_d_i, pu_en_e_i, addr_low_i, pf_pin_i, far_f, pfs, ef, nf, dn;
   logic [7:0]  pc_out_o, pc_oe_n_o, pc_pu_o, pd_out_o, pd_oe_n_o, pd_pu_o, pe_out_o, pe_oe_n_o;
   logic [7:0]  pe_pu_o, pf_out_o, pf_oe_n_o;
   logic [15:0] data_out_i;
   logic [63:0] rnd;
   int          miscompares = 0;
   int          check_count = 0;
   int          m, w;
   port_pin_function_select port_pin_function_select_inst (.*);
   bus_partner bus_partner_inst (.pf_out_i(pf_out_o), .pf_oe_n_i(pf_oe_n_o), .pg_out_i(pg_out_o),
      .pg_oe_n_i(pg_oe_n_o), .far_f_i(far_f), .far_g_i(far_g), .pf_pin_o(pf_pin_i),
      .pg_pin_o(pg_pin_i));
   initial forever #2.5 clock_i = ~clock_i;
   // ======================================
   // checking
   // ======================================
   task automatic summarize();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
      check_count++;
      if (e !== s) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // out is only meaningful where the pin drives; pull-up only on a gpio input
   task automatic prt(string n, logic bm, logic [7:0] bo, bn, d, g, p, so, sn, sp);
      logic [7:0] en;
      en = bm ? bn : ~d;
      cmp({n, " oe_n"}, en, sn);
      cmp({n, " out"}, (bm ? bo : g) & ~en, so & ~en);
      if (!bm) cmp({n, " pu"}, p & ~d, sp);
   endtask
   task automatic drive();
      rnd = {$urandom, $urandom};
      {pc_gpio_i, pd_gpio_i, pe_gpio_i, pf_gpio_i, pg_gpio_i, pu_en_c_i, pu_en_d_i} = rnd[52:0];
      rnd = {$urandom, $urandom};
      {pu_en_e_i, addr_low_i, data_out_i, data_oe_i, sys_clock_i, addr_strobe_n_i, read_strobe_n_i,
       high_write_strobe_n_i, low_write_strobe_n_i, chip_sel_n_i, far_f, far_g,
       bus_release_enable_i} = rnd[55:0];
   endtask
   task automatic compare();
      x = (m != 7);
      dn = {8{~data_oe_i}};
      if (m != 6) prt("pc", x, addr_low_i, 8'h00, pc_ddr_i, pc_gpio_i, pu_en_c_i,
                      pc_out_o, pc_oe_n_o, pc_pu_o);
      prt("pd", x, data_out_i[15:8], dn, pd_ddr_i, pd_gpio_i, pu_en_d_i,
          pd_out_o, pd_oe_n_o, pd_pu_o);
      prt("pe", x & w[0], data_out_i[7:0], dn, pe_ddr_i, pe_gpio_i, pu_en_e_i,
          pe_out_o, pe_oe_n_o, pe_pu_o);
      nf = ~pf_ddr_i;
      ef = pf_gpio_i;
      ef[7] = sys_clock_i;
      if (x) {nf[6:4], ef[6:4]} = {3'h0, addr_strobe_n_i, read_strobe_n_i, high_write_strobe_n_i};
      if (x && w == 1) {nf[3], ef[3]} = {1'b0, low_write_strobe_n_i};
      if (x && bus_release_enable_i) nf[0] = 1'b1;
      cmp("pf oe_n", nf, pf_oe_n_o);
      cmp("pf out", ef & ~nf, pf_out_o & ~nf);
      ng = ~pg_ddr_i;
      eg = pg_gpio_i;
      if (x) eg[4:1] = {chip_sel_n_i[0], chip_sel_n_i[1], chip_sel_n_i[2], chip_sel_n_i[3]};
      cmp("pg oe_n", {3'h0, ng}, {3'h0, pg_oe_n_o});
      cmp("pg out", {3'h0, eg & ~ng}, {3'h0, pg_out_o & ~ng});
      ef = {3'h0, ~(x & bus_release_enable_i) | pfs[0], pfs[0], {2{x & w[0] | pfs[3]}}, pgs[1]};
      nf = {3'h0, bus_request_in_o, ext_irq_in_2_o, ext_irq_in_3_o, converter_trigger_in_o,
            ext_irq_in_7_o};
      cmp("inputs", ef, nf);
   endtask
   // ======================================
   // each mode and bus width from reset
   // ======================================
   initial begin
      void'($urandom(94170));
      {mode_i, bus_16bit_i, ddr_write_i, pc_ddr_i, pd_ddr_i, pe_ddr_i, pf_ddr_i, pg_ddr_i} = '0;
      drive();
      for (m = 4; m < 8; m++) begin
         for (w = 0; w < 2; w++) begin
            nrst_i = 1'b0;
            mode_i = m[2:0];
            bus_16bit_i = w[0];
            repeat (3) @(negedge clock_i);
            nrst_i = 1'b1;
            repeat (2) @(negedge clock_i);
            cmp("boot", {4'h0, m != 7, m < 6, m == 7, m > 5},
                {4'h0, pf_ddr_o, pg_ddr0_o, pf_oe_n_o[7], pg_oe_n_o[4]});
            rnd = {$urandom, $urandom};
            {pc_ddr_i, pd_ddr_i, pe_ddr_i, pf_ddr_i, pg_ddr_i} = rnd[36:0];
            ddr_write_i = 1'b1;
            @(negedge clock_i);
            ddr_write_i = 1'b0;
            repeat (24) begin
               drive();
               #1;
               {pfs, pgs} = {pf_pin_i, pg_pin_i};
               @(negedge clock_i);
               compare();
            end
         end
      end
      summarize();
   end
   initial begin
      repeat (3000) @(posedge clock_i);
      miscompares++;
      summarize();
   end
endmodule
bind port_pin_function_select port_pin_function_select_chk pin_chk_inst (.*);
